//--- srt_pkg.sv
// Constants for the sensor readout timing register bank.
// Assumes a 16-bit register word reached over a four-wire serial port.
package srt_pkg;

  // Serial frame layout: address, write flag, data, most significant first
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_RW    = 5'h09;
  localparam logic [CNT_W-1:0] CNT_LAST  = 5'h19;
  localparam logic [CNT_W-1:0] CNT_DONE  = 5'h1A;

  // Base of this register page on the serial address space
  localparam logic [ADDR_W-1:0] BASE_ADDR = 9'h0C0;

  // Register offsets within the page
  localparam logic [ADDR_W-1:0] OFF_INTEG  = 9'h002;
  localparam logic [ADDR_W-1:0] OFF_REGION = 9'h004;
  localparam logic [ADDR_W-1:0] OFF_DARK   = 9'h005;
  localparam logic [ADDR_W-1:0] OFF_PAD    = 9'h006;
  localparam logic [ADDR_W-1:0] OFF_DIV    = 9'h007;
  localparam logic [ADDR_W-1:0] OFF_DUR    = 9'h008;
  localparam logic [ADDR_W-1:0] OFF_EXP    = 9'h009;
  localparam logic [ADDR_W-1:0] OFF_SPA    = 9'h00A;
  localparam logic [ADDR_W-1:0] OFF_SPB    = 9'h00B;
  localparam logic [ADDR_W-1:0] OFF_GAIN   = 9'h00C;

  // Reset values
  localparam logic [15:0] RST_INTEG  = 16'h0004;
  localparam logic [15:0] RST_REGION = 16'h0000;
  localparam logic [15:0] RST_DARK   = 16'h0102;
  localparam logic [15:0] RST_PAD    = 16'h0000;
  localparam logic [15:0] RST_DIV    = 16'h0001;
  localparam logic [15:0] RST_DUR    = 16'h0000;
  localparam logic [15:0] RST_EXP    = 16'h0000;
  localparam logic [15:0] RST_SPARE  = 16'h0000;
  localparam logic [15:0] RST_GAIN   = 16'h01E2;

  // Field positions
  localparam int unsigned SEL_BIT    = 2;
  localparam int unsigned REG_LO     = 7;
  localparam int unsigned REG_HI     = 15;
  localparam int unsigned DARK_W     = 8;
  localparam int unsigned GATE_BIT   = 8;
  localparam int unsigned PAD_W      = 12;
  localparam int unsigned GAIN_W     = 5;
  localparam logic [DARK_W-1:0] DARK_MIN = 8'h01;

endpackage

//--- srt_timing_regs.sv
// Readout timing and exposure register bank with its serial config slave.
// Assumes the sequencer drives frame_start, shutter mode and sync bits on
// clk; the serial port pins are asynchronous and resynchronised here.
//
// Function
// RULE_01: Bits 7 to 15 of the upper region word enable regions 23 to 31.
// RULE_02: The 8-bit dark-row count, reset 2, sets black lines, range 1-255.
// RULE_03: The first-line gate bit, reset 1, blanks the first readout line.
// RULE_04: The 12-bit padding row count is applied in rolling shutter only.
// RULE_05: The 16-bit tick divider, reset 1, sets global shutter time unit.
// RULE_06: The duration word is a reset length or a frame length by select.
// RULE_07: Exposure counts lines in rolling, divider ticks in global mode.
// RULE_08: Column gain is the low 5 bits of the gain word, reset 2.
// RULE_09: The length select bit, reset 1, picks 0 reset or 1 frame length.
// RULE_10: Synced settings wait for frame start; unsynced apply at once.
// RULE_11: The host writes only zero to the two spare words.
`timescale 1ns/1ps

module srt_timing_regs
  import srt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              sck,
  input  wire logic              mosi,
  input  wire logic              ss_n,
  output logic                   miso,
  output logic                   miso_oe,
  input  wire logic              frame_start,
  input  wire logic              rolling_mode,
  input  wire logic              sync_black_lines,
  input  wire logic              sync_dummy_lines,
  input  wire logic              sync_exposure,
  output logic [8:0]             region_enable_q,
  output logic [DARK_W-1:0]      black_line_count_q,
  output logic                   first_line_blank_q,
  output logic [PAD_W-1:0]       dummy_line_count_q,
  output logic [15:0]            tick_divider_q,
  output logic [15:0]            duration_q,
  output logic                   duration_is_frame_q,
  output logic [15:0]            exposure_q,
  output logic                   exposure_in_lines_q,
  output logic [GAIN_W-1:0]      column_gain_q
);

  // Address decode against the page base
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == ADDR_W'(BASE_ADDR + off));
  endfunction

  // Lowest legal dark-row count stands in for a written zero
  function automatic logic [DARK_W-1:0] clamp_dark(
    input logic [DARK_W-1:0] v);
    clamp_dark = (v == '0) ? DARK_MIN : v;
  endfunction

  // Pin synchronisers; first stages feed only the second stages
  logic sck_m_q, sck_s_q, sck_p_q;
  logic mosi_m_q, mosi_s_q;
  logic ssn_m_q, ssn_s_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_m_q  <= 1'b0;
      sck_s_q  <= 1'b0;
      sck_p_q  <= 1'b0;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
      ssn_m_q  <= 1'b1;
      ssn_s_q  <= 1'b1;
    end
    else
    begin
      sck_m_q  <= sck;
      sck_s_q  <= sck_m_q;
      sck_p_q  <= sck_s_q;
      mosi_m_q <= mosi;
      mosi_s_q <= mosi_m_q;
      ssn_m_q  <= ss_n;
      ssn_s_q  <= ssn_m_q;
    end
  end

  logic sck_rise, sck_fall;
  assign sck_rise = sck_s_q & ~sck_p_q & ~ssn_s_q;
  assign sck_fall = ~sck_s_q & sck_p_q & ~ssn_s_q;

  // Serial shifter state
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              wr_q, wr_d;
  logic [15:0]       sh_q, sh_d;
  logic [15:0]       rd_q, rd_d;
  logic              miso_d, miso_oe_d;
  logic              wr_en;
  logic [15:0]       wr_data;

  // Staging copies written by the host
  logic              sel_q, sel_d;
  logic [15:0]       region_q, region_d;
  logic [8:0]        dark_q, dark_d;
  logic [PAD_W-1:0]  pad_q, pad_d;
  logic [15:0]       div_q, div_d;
  logic [15:0]       dur_q, dur_d;
  logic [15:0]       exp_q, exp_d;
  logic [15:0]       spa_q, spa_d;
  logic [15:0]       spb_q, spb_d;
  logic [15:0]       gain_q, gain_d;

  // Read mux; unmapped addresses return zero, as do unused bits of the select, dark and padding words
  function automatic logic [15:0] rd_mux(input logic [ADDR_W-1:0] a);
    rd_mux = '0;
    if (hit(a, OFF_INTEG))  rd_mux[SEL_BIT] = sel_q;
    if (hit(a, OFF_REGION)) rd_mux = region_q;
    if (hit(a, OFF_DARK))   rd_mux = {7'h00, dark_q};
    if (hit(a, OFF_PAD))    rd_mux = {4'h0, pad_q};
    if (hit(a, OFF_DIV))    rd_mux = div_q;
    if (hit(a, OFF_DUR))    rd_mux = dur_q;
    if (hit(a, OFF_EXP))    rd_mux = exp_q;
    if (hit(a, OFF_SPA))    rd_mux = spa_q;
    if (hit(a, OFF_SPB))    rd_mux = spb_q;
    if (hit(a, OFF_GAIN))   rd_mux = gain_q;
  endfunction

  // Shift engine: sample on sck rise, drive miso after sck fall
  always_comb
  begin
    cnt_d     = cnt_q;
    addr_d    = addr_q;
    wr_d      = wr_q;
    sh_d      = sh_q;
    rd_d      = rd_q;
    miso_d    = miso;
    miso_oe_d = ~ssn_s_q & ~wr_q & (cnt_q > CNT_RW);
    wr_en     = 1'b0;
    wr_data   = {sh_q[14:0], mosi_s_q};
    if (ssn_s_q)
    begin
      cnt_d  = '0;
      miso_d = 1'b0;
    end
    else if (sck_rise && cnt_q != CNT_DONE)
    begin
      cnt_d = cnt_q + 5'h01;
      if (cnt_q < CNT_RW)
        addr_d = {addr_q[ADDR_W-2:0], mosi_s_q};
      else if (cnt_q == CNT_RW)
      begin
        wr_d = mosi_s_q;
        rd_d = rd_mux(addr_q);
      end
      else
        sh_d = wr_data;
      // Commit only on a complete frame; a short frame writes nothing
      wr_en = wr_q && (cnt_q == CNT_LAST);
    end
    else if (sck_fall && !wr_q && cnt_q > CNT_RW)
    begin
      miso_d = rd_q[15];
      rd_d   = {rd_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q   <= '0;
      addr_q  <= '0;
      wr_q    <= 1'b0;
      sh_q    <= '0;
      rd_q    <= '0;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wr_q    <= wr_d;
      sh_q    <= sh_d;
      rd_q    <= rd_d;
      miso    <= miso_d;
      miso_oe <= miso_oe_d;
    end
  end

  // Staging registers take host writes at once
  always_comb
  begin
    sel_d    = sel_q;
    region_d = region_q;
    dark_d   = dark_q;
    pad_d    = pad_q;
    div_d    = div_q;
    dur_d    = dur_q;
    exp_d    = exp_q;
    spa_d    = spa_q;
    spb_d    = spb_q;
    gain_d   = gain_q;
    if (wr_en)
    begin
      if (hit(addr_q, OFF_INTEG))  sel_d = wr_data[SEL_BIT];     // [RULE_09]
      if (hit(addr_q, OFF_REGION)) region_d = wr_data;
      if (hit(addr_q, OFF_DARK))   dark_d = wr_data[8:0];
      if (hit(addr_q, OFF_PAD))    pad_d = wr_data[PAD_W-1:0];
      if (hit(addr_q, OFF_DIV))    div_d = wr_data;
      if (hit(addr_q, OFF_DUR))    dur_d = wr_data;
      if (hit(addr_q, OFF_EXP))    exp_d = wr_data;
      // Spares only hold and return what the host leaves there
      if (hit(addr_q, OFF_SPA))    spa_d = wr_data;              // [RULE_11]
      if (hit(addr_q, OFF_SPB))    spb_d = wr_data;              // [RULE_11]
      if (hit(addr_q, OFF_GAIN))   gain_d = wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_q    <= RST_INTEG[SEL_BIT];
      region_q <= RST_REGION;
      dark_q   <= RST_DARK[8:0];
      pad_q    <= RST_PAD[PAD_W-1:0];
      div_q    <= RST_DIV;
      dur_q    <= RST_DUR;
      exp_q    <= RST_EXP;
      spa_q    <= RST_SPARE;
      spb_q    <= RST_SPARE;
      gain_q   <= RST_GAIN;
    end
    else
    begin
      sel_q    <= sel_d;
      region_q <= region_d;
      dark_q   <= dark_d;
      pad_q    <= pad_d;
      div_q    <= div_d;
      dur_q    <= dur_d;
      exp_q    <= exp_d;
      spa_q    <= spa_d;
      spb_q    <= spb_d;
      gain_q   <= gain_d;
    end
  end

  // Active settings seen by the sequencer, one cycle behind staging, the padding row count two
  logic [PAD_W-1:0] pad_act_q, pad_act_d;
  logic             upd_black, upd_pad, upd_exp;
  logic [8:0]       region_en_d;
  logic [DARK_W-1:0] black_d;
  logic             blank_d;
  logic [PAD_W-1:0] dummy_d;
  logic [15:0]      tick_d, duration_d, exposure_d;
  logic             is_frame_d;
  logic             in_lines_d;
  logic [GAIN_W-1:0] col_gain_d;

  always_comb
  begin
    upd_black  = frame_start | ~sync_black_lines;                // [RULE_10]
    upd_pad    = frame_start | ~sync_dummy_lines;                // [RULE_10]
    upd_exp    = frame_start | ~sync_exposure;                   // [RULE_10]
    region_en_d = region_q[REG_HI:REG_LO];                       // [RULE_01]
    black_d    = black_line_count_q;
    blank_d    = first_line_blank_q;
    pad_act_d  = pad_act_q;
    tick_d     = tick_divider_q;
    duration_d = duration_q;
    is_frame_d = duration_is_frame_q;
    exposure_d = exposure_q;
    if (upd_black)
    begin
      black_d = clamp_dark(dark_q[DARK_W-1:0]);                  // [RULE_02]
      blank_d = dark_q[GATE_BIT];                                // [RULE_03]
    end
    if (upd_pad)
      pad_act_d = pad_q;
    if (upd_exp)
    begin
      tick_d     = div_q;                                        // [RULE_05]
      duration_d = dur_q;                                        // [RULE_06]
      is_frame_d = sel_q;                                        // [RULE_09]
      exposure_d = exp_q;                                        // [RULE_07]
    end
    // Padding rows mean nothing in global shutter, so report none
    dummy_d    = rolling_mode ? pad_act_q : '0;                  // [RULE_04]
    in_lines_d = rolling_mode;                                   // [RULE_07]
    col_gain_d = gain_q[GAIN_W-1:0];                             // [RULE_08]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      region_enable_q     <= RST_REGION[REG_HI:REG_LO];
      black_line_count_q  <= RST_DARK[DARK_W-1:0];
      first_line_blank_q  <= RST_DARK[GATE_BIT];
      pad_act_q           <= RST_PAD[PAD_W-1:0];
      dummy_line_count_q  <= '0;
      tick_divider_q      <= RST_DIV;
      duration_q          <= RST_DUR;
      duration_is_frame_q <= RST_INTEG[SEL_BIT];
      exposure_q          <= RST_EXP;
      exposure_in_lines_q <= 1'b0;
      column_gain_q       <= RST_GAIN[GAIN_W-1:0];
    end
    else
    begin
      region_enable_q     <= region_en_d;
      black_line_count_q  <= black_d;
      first_line_blank_q  <= blank_d;
      pad_act_q           <= pad_act_d;
      dummy_line_count_q  <= dummy_d;
      tick_divider_q      <= tick_d;
      duration_q          <= duration_d;
      duration_is_frame_q <= is_frame_d;
      exposure_q          <= exposure_d;
      exposure_in_lines_q <= in_lines_d;
      column_gain_q       <= col_gain_d;
    end
  end

  // Checks on the register bank
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_write(logic [ADDR_W-1:0] off);
    wr_en && hit(addr_q, off);
  endsequence

  sequence s_unsynced_exp;
    !sync_exposure && !frame_start;
  endsequence

  AST_REGION_MAP: assert property ( // [RULE_01]
    s_write(OFF_REGION) |-> ##2 region_enable_q == $past(wr_data[15:7], 2))
    else $error("region enables do not follow the written word");

  AST_BLACK_RANGE: assert property ( // [RULE_02]
    black_line_count_q != '0)
    else $error("black line count left its legal range");

  AST_BLANK_APPLY: assert property ( // [RULE_03]
    s_write(OFF_DARK) ##1 (!sync_black_lines) |=>
      first_line_blank_q == $past(dark_q[GATE_BIT]))
    else $error("first line blanking not taken from the gate bit");

  AST_DUMMY_GLOBAL: assert property ( // [RULE_04]
    !rolling_mode |=> dummy_line_count_q == '0)
    else $error("padding rows applied in global shutter");

  AST_DIV_HOLD: assert property ( // [RULE_05]
    !$stable(tick_divider_q) |-> $past(frame_start) || !$past(sync_exposure))
    else $error("tick divider changed outside its update point");

  AST_DUR_SELECT: assert property ( // [RULE_06]
    s_write(OFF_INTEG) ##1 s_unsynced_exp |=>
      duration_is_frame_q == $past(wr_data[SEL_BIT], 2))
    else $error("duration meaning does not follow the select bit");

  AST_EXP_UNIT: assert property ( // [RULE_07]
    rolling_mode [*2] |-> ##1 exposure_in_lines_q)
    else $error("exposure unit not lines in rolling shutter");

  AST_GAIN_MAP: assert property ( // [RULE_08]
    s_write(OFF_GAIN) |-> ##2 column_gain_q == $past(wr_data[4:0], 2))
    else $error("column gain does not follow its field");

  AST_BLACK_SYNC: assert property ( // [RULE_10]
    sync_black_lines && !frame_start |=> $stable(black_line_count_q))
    else $error("synced black line count moved before frame start");

  AST_EXP_UNSYNC: assert property ( // [RULE_10]
    s_write(OFF_EXP) ##1 s_unsynced_exp |=>
      exposure_q == $past(exp_q))
    else $error("unsynced exposure did not apply at once");

endmodule

//--- srt_host_model.sv
// Host controller model driving the four-wire serial configuration port.
// Assumes the bank samples mosi on sck rise and shifts miso on sck fall.
`timescale 1ns/1ps

module srt_host_model
  import srt_pkg::*;
(
  input  wire logic clk,
  output logic      sck,
  output logic      mosi,
  output logic      ss_n,
  input  wire logic miso,
  input  wire logic miso_oe
);
  localparam int HALF = 5; // clk periods per sck phase, margin over 4
  logic last_q;
  logic miso_line;

  // Released line shows the inverse of its last level, never a stale copy
  always_ff @(posedge clk)
  begin
    if (miso_oe)
    begin
      last_q <= miso;
    end
  end
  assign miso_line = miso_oe ? miso : ~last_q;

  // Idle port: deselected, clock parked low
  initial
  begin
    sck  = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end

  // One whole 26-bit frame; read data sampled well after each sck fall
  task automatic xfer(input  logic [ADDR_W-1:0] off,
                      input  logic              wr,
                      input  logic [DATA_W-1:0] wdata,
                      output logic [DATA_W-1:0] rdata);
    logic [DATA_W-1:0] data;
    logic [25:0]       frame;
    data = wdata;
    if (wr && (off == OFF_SPA || off == OFF_SPB))
    begin
      data = 16'h0000; // Spare words only ever get zero
    end
    frame = {BASE_ADDR + off, wr, data};
    rdata = 16'h0000;
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 25; i >= 0; i--)
    begin
      mosi <= frame[i];
      repeat (HALF) @(posedge clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
      repeat (HALF) @(posedge clk);
      if (i >= 1 && i <= 16)
      begin
        rdata[i-1] = miso_line;
      end
    end
    repeat (HALF) @(posedge clk);
    ss_n <= 1'b1;
    repeat (2 * HALF) @(posedge clk);
  endtask
endmodule

//--- srt_timing_regs_test.sv
// Self-checking bench for the readout timing register bank.
// Assumes the host model owns the serial pins; bench owns sequencer inputs.
`timescale 1ns/1ps

module srt_timing_regs_test
  import srt_pkg::*;
;
  localparam int CEILING = 30000; // About twice the expected run
  logic        clk;
  logic        resetn;
  logic        sck;
  logic        mosi;
  logic        ss_n;
  logic        miso;
  logic        miso_oe;
  logic        frame_start;
  logic        rolling_mode;
  logic        sync_black_lines;
  logic        sync_dummy_lines;
  logic        sync_exposure;
  logic [8:0]  region_enable_q;
  logic [7:0]  black_line_count_q;
  logic        first_line_blank_q;
  logic [11:0] dummy_line_count_q;
  logic [15:0] tick_divider_q;
  logic [15:0] duration_q;
  logic        duration_is_frame_q;
  logic [15:0] exposure_q;
  logic        exposure_in_lines_q;
  logic [4:0]  column_gain_q;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycle_count = 0;
  logic [8:0]  reg_off [10] = '{OFF_INTEG, OFF_REGION, OFF_DARK, OFF_PAD,
    OFF_DIV, OFF_DUR, OFF_EXP, OFF_SPA, OFF_SPB, OFF_GAIN};
  logic [15:0] reg_rst [10] = '{16'h0004, 16'h0000, 16'h0102, 16'h0000,
    16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01E2};
  logic [15:0] pats [3] = '{16'h0080, 16'h8000, 16'hFF7F};

  srt_timing_regs i_srt_timing_regs (
    .clk                 (clk),
    .resetn              (resetn),
    .sck                 (sck),
    .mosi                (mosi),
    .ss_n                (ss_n),
    .miso                (miso),
    .miso_oe             (miso_oe),
    .frame_start         (frame_start),
    .rolling_mode        (rolling_mode),
    .sync_black_lines    (sync_black_lines),
    .sync_dummy_lines    (sync_dummy_lines),
    .sync_exposure       (sync_exposure),
    .region_enable_q     (region_enable_q),
    .black_line_count_q  (black_line_count_q),
    .first_line_blank_q  (first_line_blank_q),
    .dummy_line_count_q  (dummy_line_count_q),
    .tick_divider_q      (tick_divider_q),
    .duration_q          (duration_q),
    .duration_is_frame_q (duration_is_frame_q),
    .exposure_q          (exposure_q),
    .exposure_in_lines_q (exposure_in_lines_q),
    .column_gain_q       (column_gain_q)
  );

  srt_host_model i_srt_host_model (
    .clk     (clk),
    .sck     (sck),
    .mosi    (mosi),
    .ss_n    (ss_n),
    .miso    (miso),
    .miso_oe (miso_oe)
  );

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [8:0] off, input logic [15:0] data);
    logic [15:0] unused;
    i_srt_host_model.xfer(off, 1'b1, data, unused);
  endtask

  task automatic rd_chk(input logic [8:0] off, input logic [15:0] exp);
    logic [15:0] r;
    i_srt_host_model.xfer(off, 1'b0, 16'h0000, r);
    check(r, exp);
  endtask

  // Hang guard: counts as a mismatch and closes the run
  always @(posedge clk)
  begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == CEILING)
    begin
      num_errors++;
      end_sim();
    end
  end

  // Main sequence
  initial
  begin
    resetn <= 1'b0;
    frame_start <= 1'b0;
    rolling_mode <= 1'b0;
    sync_black_lines <= 1'b0;
    sync_dummy_lines <= 1'b0;
    sync_exposure <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'(region_enable_q), 16'h0000);
    check(16'(black_line_count_q), 16'h0002);
    check(16'(first_line_blank_q), 16'h0001);
    check(16'(dummy_line_count_q), 16'h0000);
    check(tick_divider_q, 16'h0001);
    check(16'(duration_is_frame_q), 16'h0001);
    check(16'(column_gain_q), 16'h0002);
    for (int k = 0; k < 10; k++)
      rd_chk(reg_off[k], reg_rst[k]);
    // Unmapped place keeps nothing
    wr(9'h00D, 16'hFFFF);
    rd_chk(9'h00D, 16'h0000);
    // Only the top nine bits reach the region enables
    for (int k = 0; k < 3; k++)
    begin
      wr(OFF_REGION, pats[k]);
      check(16'(region_enable_q), pats[k] >> 7);
      rd_chk(OFF_REGION, pats[k]);
    end
    wr(OFF_DARK, 16'h00FF);
    check(16'(black_line_count_q), 16'h00FF);
    check(16'(first_line_blank_q), 16'h0000);
    // Zero count is below range, applied as one
    wr(OFF_DARK, 16'h0100);
    check(16'(black_line_count_q), 16'h0001);
    check(16'(first_line_blank_q), 16'h0001);
    rd_chk(OFF_DARK, 16'h0100);
    rolling_mode <= 1'b1;
    wr(OFF_PAD, 16'h0FFF);
    check(16'(dummy_line_count_q), 16'h0FFF);
    check(16'(exposure_in_lines_q), 16'h0001);
    rolling_mode <= 1'b0;
    repeat (3) @(posedge clk);
    check(16'(dummy_line_count_q), 16'h0000);
    check(16'(exposure_in_lines_q), 16'h0000);
    wr(OFF_DIV, 16'hFFFF);
    wr(OFF_DUR, 16'h1234);
    wr(OFF_EXP, 16'hABCD);
    wr(OFF_INTEG, 16'h0000);
    check(tick_divider_q, 16'hFFFF);
    check(duration_q, 16'h1234);
    check(exposure_q, 16'hABCD);
    check(16'(duration_is_frame_q), 16'h0000);
    rd_chk(OFF_INTEG, 16'h0000);
    wr(OFF_INTEG, 16'h0004);
    check(16'(duration_is_frame_q), 16'h0001);
    // Held updates wait for the frame start pulse
    sync_black_lines <= 1'b1;
    sync_dummy_lines <= 1'b1;
    sync_exposure <= 1'b1;
    rolling_mode <= 1'b1;
    wr(OFF_DARK, 16'h0040);
    wr(OFF_PAD, 16'h0ABC);
    wr(OFF_EXP, 16'h5555);
    check(16'(black_line_count_q), 16'h0001);
    check(16'(dummy_line_count_q), 16'h0FFF);
    check(exposure_q, 16'hABCD);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (3) @(posedge clk);
    check(16'(black_line_count_q), 16'h0040);
    check(16'(dummy_line_count_q), 16'h0ABC);
    check(exposure_q, 16'h5555);
    sync_black_lines <= 1'b0;
    sync_dummy_lines <= 1'b0;
    sync_exposure <= 1'b0;
    wr(OFF_GAIN, 16'h00FF);
    check(16'(column_gain_q), 16'h001F);
    rd_chk(OFF_GAIN, 16'h00FF);
    wr(OFF_SPB, 16'h0000);
    rd_chk(OFF_SPB, 16'h0000);
    check(16'(miso_oe), 16'h0000);
    end_sim();
  end
endmodule
